// File: rtl/cbsu_pkg.sv
// shared constants of the clock buffer smbus upper register bank
// assumes a single 200 MHz clock and smbus pins synchronous to it
package cbsu_pkg;
    // ------------------------------------------------------------------
    // register indices
    // ------------------------------------------------------------------
    localparam logic [7:0] IDX_REV_VENDOR = 8'h05;
    localparam logic [7:0] IDX_PART_ID = 8'h06;
    localparam logic [7:0] IDX_READ_LEN = 8'h07;
    localparam logic [7:0] IDX_OUT_EN = 8'h08;
    localparam logic [7:0] IDX_RSVD_NINE = 8'h09;
    // ------------------------------------------------------------------
    // reset values and field layout
    // ------------------------------------------------------------------
    localparam logic [7:0] READ_LEN_RST = 8'h07;
    localparam logic [4:0] OUT_EN_RST = 5'h1F;
    localparam int OUT_EN_LSB = 0;
    localparam int OUT_EN_W = 5;
    localparam logic [7:0] OUT_EN_RSVD_RD = 8'h80;
    localparam logic [7:0] RSVD_NINE_RD = 8'h05;
    localparam logic [7:0] UNMAPPED_RD = 8'h00;
    // ------------------------------------------------------------------
    // smbus addressing: write address base, step of two per strap value
    // ------------------------------------------------------------------
    localparam logic [6:0] SMB_ADDR_BASE = 7'h68;
    localparam int STRAP_W = 3;
    // ------------------------------------------------------------------
    // state types
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        BIT_IDLE = 3'b000,
        BIT_RX = 3'b001,
        BIT_RACK = 3'b011,
        BIT_TX = 3'b010,
        BIT_TACK = 3'b110
    } cbsu_bit_st_t;
    typedef enum logic [2:0] {
        TR_IDLE = 3'b000,
        TR_ADDR = 3'b001,
        TR_CMD = 3'b011,
        TR_CNT = 3'b010,
        TR_WDATA = 3'b110,
        TR_READ = 3'b101
    } cbsu_tr_st_t;
endpackage : cbsu_pkg

// File: rtl/cbsu_byte_if.sv
// byte-level link between the smbus bit engine and the register bank
// assumes both ends share clk
`timescale 1ns/1ps
interface cbsu_byte_if;
    logic start;
    logic stop;
    logic rx_valid;
    logic [7:0] rx_byte;
    logic ack;
    logic tx;
    logic [7:0] tx_byte;
    logic tx_done;
    logic host_ack;
    modport engine (output start, stop, rx_valid, rx_byte, tx_done, host_ack,
                    input ack, tx, tx_byte);
    modport ctrl (input start, stop, rx_valid, rx_byte, tx_done, host_ack,
                  output ack, tx, tx_byte);
endinterface : cbsu_byte_if

// File: rtl/cbsu_smbus_engine.sv
// smbus bit engine: start/stop detection, byte shift in and out, ack slots
// assumes scl and sda already synchronous to clk; sda is open drain
`timescale 1ns/1ps
module cbsu_smbus_engine (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    cbsu_byte_if.engine bus
);
    logic scl_q_r;
    logic sda_q_r;
    logic [3:0] cnt_r;
    logic [7:0] sh_r;
    logic ack_r;
    cbsu_pkg::cbsu_bit_st_t st_r;
    logic rise;
    logic fall;

    assign rise = ~scl_q_r & scl_in;
    assign fall = scl_q_r & ~scl_in;
    assign bus.start = scl_q_r & scl_in & sda_q_r & ~sda_in;
    assign bus.stop = scl_q_r & scl_in & ~sda_q_r & sda_in;
    assign bus.rx_byte = sh_r;
    // open drain: only ever pull low
    assign sda_out = 1'b0;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            scl_q_r <= 1'b1;
            sda_q_r <= 1'b1;
        end else begin
            scl_q_r <= scl_in;
            sda_q_r <= sda_in;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_r <= cbsu_pkg::BIT_IDLE;
            cnt_r <= 4'h0;
            sh_r <= 8'h00;
            sda_oe <= 1'b0;
            ack_r <= 1'b0;
            bus.rx_valid <= 1'b0;
            bus.tx_done <= 1'b0;
            bus.host_ack <= 1'b0;
        end else begin
            bus.rx_valid <= 1'b0;
            bus.tx_done <= 1'b0;
            if (bus.start) begin
                st_r <= cbsu_pkg::BIT_RX;
                cnt_r <= 4'h0;
                sda_oe <= 1'b0;
            end else if (bus.stop) begin
                st_r <= cbsu_pkg::BIT_IDLE;
                sda_oe <= 1'b0;
            end else begin
                case (st_r)
                    cbsu_pkg::BIT_RX: begin
                        if (rise) begin
                            sh_r <= {sh_r[6:0], sda_in};
                            cnt_r <= cnt_r + 4'h1;
                            bus.rx_valid <= (cnt_r == 4'h7);
                        end else if (fall && cnt_r == 4'h8) begin
                            // answer decided by the bank in the meantime
                            sda_oe <= bus.ack;
                            st_r <= bus.ack ? cbsu_pkg::BIT_RACK : cbsu_pkg::BIT_IDLE;
                        end
                    end
                    cbsu_pkg::BIT_RACK: begin
                        if (fall) begin
                            cnt_r <= 4'h0;
                            if (bus.tx) begin
                                sh_r <= bus.tx_byte;
                                sda_oe <= ~bus.tx_byte[7];
                                st_r <= cbsu_pkg::BIT_TX;
                            end else begin
                                sda_oe <= 1'b0;
                                st_r <= cbsu_pkg::BIT_RX;
                            end
                        end
                    end
                    cbsu_pkg::BIT_TX: begin
                        if (rise) begin
                            cnt_r <= cnt_r + 4'h1;
                        end else if (fall) begin
                            if (cnt_r == 4'h8) begin
                                sda_oe <= 1'b0;
                                st_r <= cbsu_pkg::BIT_TACK;
                            end else begin
                                sh_r <= {sh_r[6:0], 1'b0};
                                sda_oe <= ~sh_r[6];
                            end
                        end
                    end
                    cbsu_pkg::BIT_TACK: begin
                        if (rise) begin
                            ack_r <= ~sda_in;
                            bus.host_ack <= ~sda_in;
                            bus.tx_done <= 1'b1;
                        end else if (fall) begin
                            cnt_r <= 4'h0;
                            // a not-acknowledge ends the read; wait for stop
                            if (ack_r) begin
                                sh_r <= bus.tx_byte;
                                sda_oe <= ~bus.tx_byte[7];
                                st_r <= cbsu_pkg::BIT_TX;
                            end else begin
                                st_r <= cbsu_pkg::BIT_IDLE;
                            end
                        end
                    end
                    default: begin
                        sda_oe <= 1'b0;
                    end
                endcase
            end
        end
    end
endmodule : cbsu_smbus_engine

// File: rtl/cbsu_upper_regs.sv
// upper smbus register bank of a differential clock fanout buffer
// assumes an smbus host on scl/sda and address straps stable after reset
// Behaviour
// - index 5 read-only revision and vendor nibbles
// - index 7 writable block-read length
// - read length resets to seven
// - index 8 bits 4..0 gate outputs 18..14
// - address D0..DE in steps of two by straps
// - block read returns count, then bytes from index
`timescale 1ns/1ps
module cbsu_upper_regs #(
    // arbitrary identification values, not those of any part
    parameter logic [3:0] REVISION_CODE = 4'h3,
    parameter logic [3:0] VENDOR_CODE = 4'h5,
    parameter logic [7:0] PART_ID_RST = 8'hA5,
    // strap values that select bypass mode with the pll off
    parameter logic [7:0] BYPASS_STRAP_MASK = 8'hFF
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic [cbsu_pkg::STRAP_W-1:0] addr_strap,
    output logic pll_bypass,
    output logic clock_output_14_enable,
    output logic clock_output_15_enable,
    output logic clock_output_16_enable,
    output logic clock_output_17_enable,
    output logic clock_output_18_enable
);
    cbsu_byte_if bus ();

    logic [cbsu_pkg::STRAP_W-1:0] strap_r;
    logic strap_done_r;
    logic pll_bypass_r;
    logic [7:0] part_id_r;
    logic [7:0] read_len_r;
    logic [cbsu_pkg::OUT_EN_W-1:0] out_en_r;
    logic [7:0] idx_r;
    logic [7:0] wcount_r;
    logic ack_r;
    logic tx_r;
    logic [7:0] tx_byte_r;
    logic wr_en;
    logic [6:0] my_addr;
    cbsu_pkg::cbsu_tr_st_t st_r;

    // ------------------------------------------------------------------
    // bit engine and byte link
    // ------------------------------------------------------------------
    cbsu_smbus_engine u_engine (
        .clk(clk),
        .arst_n(arst_n),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .sda_out(sda_out),
        .sda_oe(sda_oe),
        .bus(bus)
    );

    assign bus.ack = ack_r;
    assign bus.tx = tx_r;
    assign bus.tx_byte = tx_byte_r;

    // ------------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------------
    function automatic logic [7:0] rd_byte(input logic [7:0] idx);
        logic [7:0] v;
        v = cbsu_pkg::UNMAPPED_RD;
        case (idx)
            cbsu_pkg::IDX_REV_VENDOR: v = {REVISION_CODE, VENDOR_CODE};
            cbsu_pkg::IDX_PART_ID: v = part_id_r;
            cbsu_pkg::IDX_READ_LEN: v = read_len_r;
            cbsu_pkg::IDX_OUT_EN: v = cbsu_pkg::OUT_EN_RSVD_RD | 8'(out_en_r);
            cbsu_pkg::IDX_RSVD_NINE: v = cbsu_pkg::RSVD_NINE_RD;
            default: v = cbsu_pkg::UNMAPPED_RD;
        endcase
        return v;
    endfunction : rd_byte

    // ------------------------------------------------------------------
    // address straps
    // ------------------------------------------------------------------
    // straps caught once after reset release, so a later pin change
    // cannot move the device on a live bus
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            strap_r <= '0;
            strap_done_r <= 1'b0;
            pll_bypass_r <= 1'b0;
        end else if (!strap_done_r) begin
            strap_r <= addr_strap;
            strap_done_r <= 1'b1;
            pll_bypass_r <= BYPASS_STRAP_MASK[addr_strap];
        end
    end

    assign my_addr = cbsu_pkg::SMB_ADDR_BASE + 7'(strap_r);
    assign pll_bypass = pll_bypass_r;

    // ------------------------------------------------------------------
    // transaction sequencer
    // ------------------------------------------------------------------
    assign wr_en = (st_r == cbsu_pkg::TR_WDATA) && bus.rx_valid && (wcount_r != 8'h00);

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_r <= cbsu_pkg::TR_IDLE;
            idx_r <= 8'h00;
            wcount_r <= 8'h00;
            ack_r <= 1'b0;
            tx_r <= 1'b0;
            tx_byte_r <= 8'h00;
        end else if (bus.start) begin
            // also a repeated start: index from the command byte is kept
            st_r <= cbsu_pkg::TR_ADDR;
            ack_r <= 1'b0;
            tx_r <= 1'b0;
        end else if (bus.stop) begin
            st_r <= cbsu_pkg::TR_IDLE;
            ack_r <= 1'b0;
            tx_r <= 1'b0;
        end else begin
            case (st_r)
                cbsu_pkg::TR_ADDR: begin
                    if (bus.rx_valid) begin
                        if (bus.rx_byte[7:1] == my_addr) begin
                            ack_r <= 1'b1;
                            tx_r <= bus.rx_byte[0];
                            tx_byte_r <= read_len_r;
                            st_r <= bus.rx_byte[0] ? cbsu_pkg::TR_READ : cbsu_pkg::TR_CMD;
                        end else begin
                            ack_r <= 1'b0;
                            st_r <= cbsu_pkg::TR_IDLE;
                        end
                    end
                end
                cbsu_pkg::TR_CMD: begin
                    if (bus.rx_valid) begin
                        idx_r <= bus.rx_byte;
                        ack_r <= 1'b1;
                        st_r <= cbsu_pkg::TR_CNT;
                    end
                end
                cbsu_pkg::TR_CNT: begin
                    if (bus.rx_valid) begin
                        wcount_r <= bus.rx_byte;
                        ack_r <= 1'b1;
                        st_r <= cbsu_pkg::TR_WDATA;
                    end
                end
                cbsu_pkg::TR_WDATA: begin
                    if (bus.rx_valid) begin
                        // bytes beyond the announced count are refused
                        ack_r <= wr_en;
                        if (wr_en) begin
                            idx_r <= idx_r + 8'h01;
                            wcount_r <= wcount_r - 8'h01;
                        end
                    end
                end
                cbsu_pkg::TR_READ: begin
                    // data bytes from index onward, one per host ack
                    // no stop at the count: the host ends the read by its nack
                    if (bus.tx_done && bus.host_ack) begin
                        tx_byte_r <= rd_byte(idx_r);
                        idx_r <= idx_r + 8'h01;
                    end
                end
                default: begin
                    ack_r <= 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // writable registers
    // ------------------------------------------------------------------
    // index 5 has no write path
    // reserved bits and index 9 have no storage
    // index 6 is writable, so the part code is only a power-up default
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            part_id_r <= PART_ID_RST;
            read_len_r <= cbsu_pkg::READ_LEN_RST;
            out_en_r <= cbsu_pkg::OUT_EN_RST;
        end else if (wr_en) begin
            case (idx_r)
                cbsu_pkg::IDX_PART_ID: part_id_r <= bus.rx_byte;
                cbsu_pkg::IDX_READ_LEN: read_len_r <= bus.rx_byte;
                // only the five gate bits store
                cbsu_pkg::IDX_OUT_EN:
                    out_en_r <= bus.rx_byte[cbsu_pkg::OUT_EN_LSB +: cbsu_pkg::OUT_EN_W];
                default: begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // output enable pins
    // ------------------------------------------------------------------
    // only the gates leave the block; the output drivers sit outside it
    // zero places the output in high impedance
    assign clock_output_14_enable = out_en_r[0];
    assign clock_output_15_enable = out_en_r[1];
    assign clock_output_16_enable = out_en_r[2];
    assign clock_output_17_enable = out_en_r[3];
    assign clock_output_18_enable = out_en_r[4];
endmodule : cbsu_upper_regs

// File: tb/cbsu_upper_regs_checker.sv
// pin-level assertions for the upper smbus register bank
// assumes scl_in and sda_in are synchronous to clk
`timescale 1ns/1ps
module cbsu_upper_regs_checker #(
    parameter logic [7:0] BYPASS_STRAP_MASK = 8'hFF
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic [cbsu_pkg::STRAP_W-1:0] addr_strap,
    input wire logic pll_bypass,
    input wire logic clock_output_14_enable,
    input wire logic clock_output_15_enable,
    input wire logic clock_output_16_enable,
    input wire logic clock_output_17_enable,
    input wire logic clock_output_18_enable
);
    logic [4:0] en;
    assign en = {clock_output_18_enable, clock_output_17_enable, clock_output_16_enable,
                 clock_output_15_enable, clock_output_14_enable};
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);
    sequence stop_seen;
        scl_in && $past(scl_in) && $rose(sda_in);
    endsequence
    chk_drive_low_only: assert property (sda_out == 1'b0)
        else $error("sda driven high");
    chk_reset_values: assert property ($rose(arst_n) |-> en == 5'h1F && !sda_oe && !pll_bypass)
        else $error("wrong values out of reset");
    chk_bypass_map: assert property (arst_n && $past(arst_n) |-> pll_bypass == BYPASS_STRAP_MASK[addr_strap])
        else $error("bypass does not follow strap");
    // capture lands on the first edge after release, so look from the third on
    chk_bypass_steady: assert property (
        arst_n && $past(arst_n) && $past(arst_n, 2) |-> $stable(pll_bypass))
        else $error("bypass changed after capture");
    chk_en_scl_high: assert property ($changed(en) |-> scl_in && $past(scl_in))
        else $error("enables changed outside a data bit");
    chk_en_scl_low: assert property (!scl_in && !$past(scl_in) |-> $stable(en))
        else $error("enables changed while scl low");
    chk_oe_scl_low: assert property ($changed(sda_oe) |-> !$past(scl_in) && !scl_in)
        else $error("sda enable moved while scl high");
    chk_oe_after_stop: assert property (stop_seen |=> !sda_oe [*3])
        else $error("sda driven after stop");
    cover property ($fell(clock_output_18_enable));
    cover property ($rose(sda_oe));
    cover property (stop_seen);
endmodule : cbsu_upper_regs_checker
bind cbsu_upper_regs cbsu_upper_regs_checker #(.BYPASS_STRAP_MASK(BYPASS_STRAP_MASK)) u_chk (
    .clk(clk), .arst_n(arst_n), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
    .sda_oe(sda_oe), .addr_strap(addr_strap), .pll_bypass(pll_bypass),
    .clock_output_14_enable(clock_output_14_enable),
    .clock_output_15_enable(clock_output_15_enable),
    .clock_output_16_enable(clock_output_16_enable),
    .clock_output_17_enable(clock_output_17_enable),
    .clock_output_18_enable(clock_output_18_enable));

// File: tb/cbsu_smbus_host.sv
// smbus host model: start, stop and byte transfers on scl/sda
// assumes the bench resolves sda from both open-drain enables
`timescale 1ns/1ps
module cbsu_smbus_host (
    input wire logic clk,
    input wire logic sda,
    output logic scl,
    output logic sda_oe
);
    // scl idles high, as the pull-up leaves it between frames
    initial begin
        scl = 1'b1;
        sda_oe = 1'b0;
    end
    task automatic hold(input int n);
        repeat (n) @(posedge clk);
    endtask : hold
    // start is line(0,1), stop is line(1,0); sda_oe is set to a while scl low, then moves to b while scl high
    task automatic line(input logic a, input logic b);
        scl <= 1'b0;
        hold(2);
        sda_oe <= a;
        hold(3);
        scl <= 1'b1;
        hold(4);
        sda_oe <= b;
        hold(4);
    endtask : line
    task automatic put_bit(input logic b, output logic r);
        scl <= 1'b0;
        hold(2);
        sda_oe <= ~b;
        hold(3);
        scl <= 1'b1;
        hold(2);
        r = sda;
        hold(2);
    endtask : put_bit
    task automatic xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] q,
                        output logic ack_out);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            put_bit(d[i], r);
            q[i] = r;
        end
        put_bit(ack_in, ack_out);
    endtask : xfer
endmodule : cbsu_smbus_host

// File: tb/testbench.sv
// self-checking bench for the upper smbus register bank
// assumes the host model drives scl/sda; sda resolved with a pull-up
`timescale 1ns/1ps
module testbench;
    // arbitrary identification values
    localparam logic [3:0] REV = 4'h3;
    localparam logic [3:0] VEN = 4'h9;
    localparam logic [7:0] PID = 8'h3C;
    localparam logic [7:0] MASK = 8'hA6;
    logic clk, arst_n, host_scl, host_oe, sda_oe, sda_out, sda, pll_bypass;
    logic [2:0] strap;
    logic [4:0] en;
    logic [7:0] ak;
    logic [7:0] mdl [0:255];
    logic [7:0] rb [0:7];
    logic [7:0] pick [0:6] = '{8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0A, 8'hC3};
    int error_cnt = 0;
    int total_checks = 0;
    assign sda = !(host_oe || sda_oe);
    cbsu_upper_regs #(.REVISION_CODE(REV), .VENDOR_CODE(VEN), .PART_ID_RST(PID),
        .BYPASS_STRAP_MASK(MASK)) DUT (.clk(clk), .arst_n(arst_n), .scl_in(host_scl),
        .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .addr_strap(strap),
        .pll_bypass(pll_bypass), .clock_output_14_enable(en[0]),
        .clock_output_15_enable(en[1]), .clock_output_16_enable(en[2]),
        .clock_output_17_enable(en[3]), .clock_output_18_enable(en[4]));
    cbsu_smbus_host HOST (.clk(clk), .sda(sda), .scl(host_scl), .sda_oe(host_oe));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic stop_test();
        if (error_cnt == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : stop_test
    function automatic logic [6:0] own(input logic [2:0] s);
        return cbsu_pkg::SMB_ADDR_BASE + 7'(s);
    endfunction : own
    function automatic logic [7:0] after_write(input logic [7:0] idx, old, d);
        case (idx)
            8'h06, 8'h07: return d;
            8'h08: return 8'h80 | {3'h0, d[4:0]};
            default: return old;
        endcase
    endfunction : after_write
    task automatic do_reset(input logic [2:0] s);
        arst_n <= 1'b0;
        strap <= s;
        repeat (20) @(posedge clk);
        arst_n <= 1'b1;
        for (int i = 0; i < 256; i++) mdl[i] = 8'h00;
        mdl[5] = {REV, VEN};
        mdl[6] = PID;
        mdl[7] = 8'h07;
        mdl[8] = 8'h9F;
        mdl[9] = 8'h05;
        repeat (2) @(posedge clk);
    endtask : do_reset
    // address, index, count of one, then nb data bytes
    task automatic wr(input logic [6:0] a, input logic [7:0] idx, d, input int nb);
        logic [7:0] q;
        logic k;
        logic [7:0] b [0:4];
        b = '{{a, 1'b0}, idx, 8'h01, d, d};
        ak = 8'hFF;
        HOST.line(1'b0, 1'b1);
        for (int i = 0; i < nb + 3; i++) begin
            HOST.xfer(b[i], 1'b1, q, k);
            ak[i] = k;
        end
        HOST.line(1'b1, 1'b0);
    endtask : wr
    task automatic rd(input logic [6:0] a, input logic [7:0] idx, input int n);
        logic [7:0] q;
        logic k;
        HOST.line(1'b0, 1'b1);
        HOST.xfer({a, 1'b0}, 1'b1, q, k);
        ak[0] = k;
        HOST.xfer(idx, 1'b1, q, k);
        ak[1] = k;
        HOST.line(1'b0, 1'b1);
        HOST.xfer({a, 1'b1}, 1'b1, q, k);
        ak[2] = k;
        for (int i = 0; i <= n; i++) begin
            HOST.xfer(8'hFF, i == n, q, k);
            rb[i] = q;
        end
        HOST.line(1'b1, 1'b0);
        check({5'h0, ak[2:0]}, 8'h00);
        check({7'h0, sda_out}, 8'h00);
        check(rb[0], mdl[7]);
        for (int i = 0; i < n; i++) check(rb[i + 1], mdl[8'(idx + i)]);
    endtask : rd
    initial begin
        repeat (90000) @(posedge clk);
        error_cnt++;
        stop_test();
    end
    initial begin
        logic [7:0] d, idx;
        logic [6:0] a;
        arst_n = 1'b0;
        strap = 3'h0;
        void'($urandom(32'h4EA24750));
        for (int i = 0; i < 8; i++) begin
            do_reset(3'(i));
            check({7'h0, pll_bypass}, {7'h0, MASK[i]});
            check({3'h0, en}, 8'h1F);
            d = 8'($urandom);
            wr(own(3'(i)), 8'h08, d, 1);
            check({4'h0, ak[3:0]}, 8'h00);
            check({3'h0, en}, {3'h0, d[4:0]});
            wr(own(3'(i + 1)), 8'h08, ~d, 1);
            check({4'h0, ak[3:0]}, 8'h0F);
            check({3'h0, en}, {3'h0, d[4:0]});
        end
        do_reset(3'($urandom));
        a = own(strap);
        rd(a, 8'h05, 7);
        repeat (14) begin
            idx = pick[$urandom_range(0, 6)];
            d = 8'($urandom);
            wr(a, idx, d, 1);
            check({4'h0, ak[3:0]}, 8'h00);
            mdl[idx] = after_write(idx, mdl[idx], d);
            rd(a, idx, 3);
        end
        d = 8'($urandom);
        wr(a, 8'h06, d, 2);
        check({7'h0, ak[4]}, 8'h01);
        mdl[6] = d;
        rd(a, 8'h06, 2);
        stop_test();
    end
endmodule : testbench
